/* logic/tape_port.sv */
// Overview of operation
// RL1: Reader flag lead edge steps 1-2, 3-0
// RL2: Trail jumper: flag trailing edge steps 2-3
// RL3: Capture input data only at counts 1, 3
// RL4: Response mode holds command until flag
// RL5: Polarity jumper absent drives command true
// RL6: Halt jumper absent never halts host
// RL7: Reader status 9 rise requests interrupt
// RL8: Punch falling flag steps 1-2, 3-0
// RL9: Punch falling flag steps 2-3, signals done
// RL10: Punch status 8, 9 rises request interrupt
// RL11: Status 10 interrupts only with jumper
// RL12: Output lines static during input transfer; the code holds them only while the hold jumper is absent
// RL13: Tape fault sets clear-interface bit 12
// RL14: Status word bits in fixed order
// RL15: Step 3 to 0 completes word
`timescale 1ns/1ps
`default_nettype none
module tape_port #(
	parameter int TIMEOUT_CYC = tape_port_pkg::TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_B,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Jumpers
	input  wire logic        HALT_OPTION_JUMPER,
	input  wire logic        FLAG_LEAD_EDGE_JUMPER,
	input  wire logic        RESPONSE_MODE_JUMPER,
	input  wire logic        INPUT_ENABLE_JUMPER,
	input  wire logic        FLAG_TRAIL_EDGE_JUMPER,
	input  wire logic        OUTPUT_HOLD_JUMPER,
	input  wire logic        STATUS9_IRQ_JUMPER,
	input  wire logic        STATUS10_IRQ_JUMPER,
	input  wire logic        COMMAND_POLARITY_JUMPER,
	// Peripheral inputs
	input  wire logic        SPROCKET_HOLE_DETECT,
	input  wire logic        STATUS8,
	input  wire logic        STATUS9,
	input  wire logic        STATUS10,
	input  wire logic        POWER_ON,
	input  wire logic        SUPPLY_LOW,
	input  wire logic        TAPE_FAULT,
	input  wire logic [7:0]  DATA_IN,
	// Peripheral outputs
	output logic             DEVICE_COMMAND,
	output logic      [7:0]  DATA_OUT,
	output logic             OPERATION_COMPLETE,
	// Host halt request
	output logic             IO_HALT
);
	// ==========================================
	// Pin synchronisation
	logic [tape_port_pkg::PIN_W-1:0] pin_lvl; // Settled pins
	logic [tape_port_pkg::PIN_W-1:0] pin_rise; // Rising edges
	logic [tape_port_pkg::PIN_W-1:0] pin_fall; // Falling edges

	pin_sync #(.W(tape_port_pkg::PIN_W)) u_sync (
		.clk   (CLOCK),
		.rst_b (RST_B),
		.raw   ({DATA_IN, COMMAND_POLARITY_JUMPER, STATUS10_IRQ_JUMPER,
		         STATUS9_IRQ_JUMPER, OUTPUT_HOLD_JUMPER, FLAG_TRAIL_EDGE_JUMPER,
		         INPUT_ENABLE_JUMPER, RESPONSE_MODE_JUMPER, FLAG_LEAD_EDGE_JUMPER,
		         HALT_OPTION_JUMPER, TAPE_FAULT, SUPPLY_LOW, POWER_ON, STATUS10,
		         STATUS9, STATUS8, SPROCKET_HOLE_DETECT}),
		.level (pin_lvl),
		.rise  (pin_rise),
		.fall  (pin_fall)
	);

	// Named views of the jumpers
	logic j_halt, j_lead, j_resp, j_inen, j_trail, j_hold, j_s9, j_s10, j_pol;
	assign j_halt  = pin_lvl[tape_port_pkg::PIN_J];
	assign j_lead  = pin_lvl[tape_port_pkg::PIN_J + 1];
	assign j_resp  = pin_lvl[tape_port_pkg::PIN_J + 2];
	assign j_inen  = pin_lvl[tape_port_pkg::PIN_J + 3];
	assign j_trail = pin_lvl[tape_port_pkg::PIN_J + 4];
	assign j_hold  = pin_lvl[tape_port_pkg::PIN_J + 5];
	assign j_s9    = pin_lvl[tape_port_pkg::PIN_J + 6];
	assign j_s10   = pin_lvl[tape_port_pkg::PIN_J + 7];
	assign j_pol   = pin_lvl[tape_port_pkg::PIN_J + 8];

	// ==========================================
	// Bus slave
	logic        dp_write;  // Write data phase pending
	logic [7:0]  dp_addr;   // Latched offset
	logic        next_dp_write;
	logic [7:0]  next_dp_addr;
	logic [31:0] next_hrdata;
	logic        addr_ok;   // Valid address phase
	logic [15:0] status;    // Live status word
	logic [15:0] data_in;   // Assembled read word

	assign addr_ok = HSEL && HREADY && (HTRANS == tape_port_pkg::HTRANS_NONSEQ
		|| HTRANS == tape_port_pkg::HTRANS_SEQ);

	// Decode address phase, prepare read data
	always_comb begin
		next_dp_write = addr_ok && HWRITE;
		next_dp_addr  = addr_ok ? HADDR[7:0] : 8'h00;
		next_hrdata   = 32'h00000000;
		if (addr_ok && !HWRITE) begin
			case (HADDR[7:0])
				tape_port_pkg::OFS_STATUS: next_hrdata = {16'h0000, status};
				tape_port_pkg::OFS_DATAIN: next_hrdata = {16'h0000, data_in};
				default:                   next_hrdata = 32'h00000000;
			endcase
		end
	end

	// Zero wait states, always OKAY
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			dp_write  <= 1'b0;
			dp_addr   <= 8'h00;
			HRDATA    <= 32'h00000000;
			HREADYOUT <= 1'b0;
			HRESP     <= 1'b0;
		end else begin
			dp_write  <= next_dp_write;
			dp_addr   <= next_dp_addr;
			HRDATA    <= next_hrdata;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	// Write strobes seen in the data phase
	logic wr_ctl, wr_dout;
	assign wr_ctl  = dp_write && dp_addr == tape_port_pkg::OFS_CONTROL;
	assign wr_dout = dp_write && dp_addr == tape_port_pkg::OFS_DATAOUT;

	// ==========================================
	// Sequencer state
	typedef enum {SEQ_IDLE, SEQ_RUN} phase_t;
	phase_t      phase, next_phase;   // Transfer in progress
	logic [1:0]  cnt, next_cnt;       // Sequence counter
	logic        punch, next_punch;   // Punch configuration
	logic [15:0] out_word, next_out_word;
	logic [15:0] next_data_in;
	logic [4:0]  pulse, next_pulse;   // Command pulse length
	logic [31:0] timer, next_timer;   // Watchdog
	logic        cmd, next_cmd;       // True command level
	logic [7:0]  next_dout;
	logic        next_operation_complete, next_halt;
	logic        start_ok, write_ok, xfer, clrif, io_int, xerr, tout;
	logic        next_start_ok, next_write_ok, next_xfer, next_clrif;
	logic        next_io_int, next_xerr, next_tout;
	logic        e_lead, e_23, clear, reading, word_done, step_23;

	// Active flag edges for each step
	always_comb begin
		e_lead = (punch ^ j_lead) ? pin_fall[tape_port_pkg::PIN_FLAG]
		                          : pin_rise[tape_port_pkg::PIN_FLAG]; // [RL1] [RL8]
		e_23 = j_trail ? pin_fall[tape_port_pkg::PIN_FLAG] : e_lead; // [RL2] [RL9]
	end

	assign clear     = wr_ctl && HWDATA[tape_port_pkg::CTL_CLEAR];
	assign reading   = phase == SEQ_RUN && !punch;
	assign word_done = phase == SEQ_RUN && cnt == 2'h3 && e_lead; // [RL15]
	assign step_23   = phase == SEQ_RUN && cnt == 2'h2 && e_23;

	// Next values of the sequencer
	always_comb begin
		next_phase    = phase;
		next_cnt      = cnt;
		next_punch    = punch;
		next_out_word = out_word;
		next_data_in  = data_in;
		next_pulse    = pulse;
		next_timer    = timer;
		next_operation_complete  = 1'b0;
		next_halt     = IO_HALT;
		next_dout     = DATA_OUT;
		// Control order
		if (wr_ctl) begin
			next_punch = HWDATA[tape_port_pkg::CTL_PUNCH];
		end
		// New punch word
		if (wr_dout) begin
			next_out_word = HWDATA[15:0];
		end
		case (phase)
			SEQ_IDLE: begin
				next_timer = 32'h00000000;
				if (wr_ctl && HWDATA[tape_port_pkg::CTL_START]) begin
					next_phase = SEQ_RUN;
					next_cnt   = 2'h1;
					next_pulse = 5'(tape_port_pkg::CMD_PULSE_CYC);
					next_halt  = j_halt; // [RL6]
				end
			end
			SEQ_RUN: begin
				next_timer = timer + 32'h00000001;
				if (pulse != 5'h00) begin
					next_pulse = pulse - 5'h01;
				end
				// Capture a byte on the lead edge
				if (e_lead && !punch && !j_inen && (cnt == 2'h1 || cnt == 2'h3)) begin
					if (cnt == 2'h1) begin
						next_data_in[15:8] = pin_lvl[tape_port_pkg::PIN_DATA +: 8]; // [RL3]
					end else begin
						next_data_in[7:0] = pin_lvl[tape_port_pkg::PIN_DATA +: 8]; // [RL3]
					end
				end
				case (cnt)
					2'h1: begin
						if (e_lead) begin
							next_cnt = 2'h2; // [RL1] [RL8]
						end
					end
					2'h2: begin
						if (e_23) begin
							next_cnt     = 2'h3; // [RL2] [RL9]
							next_pulse   = 5'(tape_port_pkg::CMD_PULSE_CYC);
							next_operation_complete = punch; // [RL9]
						end
					end
					2'h3: begin
						if (e_lead) begin
							next_cnt   = 2'h0; // [RL15]
							next_phase = SEQ_IDLE;
							next_halt  = 1'b0;
						end
					end
					default: begin
						next_cnt = cnt;
					end
				endcase
				// Watchdog aborts a stuck transfer
				if (timer >= 32'(TIMEOUT_CYC - 1)) begin
					next_phase = SEQ_IDLE;
					next_cnt   = 2'h0;
					next_halt  = 1'b0;
				end
			end
			default: begin
				next_phase = SEQ_IDLE;
			end
		endcase
		// Command while a byte is requested
		if (next_phase == SEQ_RUN && (next_cnt == 2'h1 || next_cnt == 2'h3)) begin
			next_cmd = j_resp ? 1'b1 : (next_pulse != 5'h00); // [RL4]
		end else begin
			next_cmd = 1'b0;
		end
		// Byte to punch, frozen while reading when the hold jumper is absent
		if (!reading || j_hold) begin
			next_dout = (next_cnt == 2'h3) ? out_word[7:0] : out_word[15:8]; // [RL12]
		end
	end

	// Register the sequencer
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			phase              <= SEQ_IDLE;
			cnt                <= 2'h0;
			punch              <= tape_port_pkg::CTL_PUNCH_RST;
			out_word           <= 16'h0000;
			data_in            <= 16'h0000;
			pulse              <= 5'h00;
			timer              <= 32'h00000000;
			cmd                <= 1'b0;
			DEVICE_COMMAND     <= 1'b0;
			DATA_OUT           <= 8'h00;
			OPERATION_COMPLETE <= 1'b0;
			IO_HALT            <= 1'b0;
		end else begin
			phase              <= next_phase;
			cnt                <= next_cnt;
			punch              <= next_punch;
			out_word           <= next_out_word;
			data_in            <= next_data_in;
			pulse              <= next_pulse;
			timer              <= next_timer;
			cmd                <= next_cmd;
			DEVICE_COMMAND     <= next_cmd ^ j_pol; // [RL5]
			DATA_OUT           <= next_dout;
			OPERATION_COMPLETE <= next_operation_complete;
			IO_HALT            <= next_halt;
		end
	end

	// ==========================================
	// Sticky status bits, set wins over clear
	logic irq_edge; // Status line event
	always_comb begin
		irq_edge = (j_s9 && pin_rise[tape_port_pkg::PIN_S9]) // [RL7] [RL10]
			|| (punch && pin_rise[tape_port_pkg::PIN_S8])     // [RL10]
			|| (j_s10 && pin_fall[tape_port_pkg::PIN_S10]);   // [RL11]
		next_start_ok = (start_ok && !clear) || (wr_ctl && HWDATA[tape_port_pkg::CTL_START]
			&& phase == SEQ_IDLE);
		next_xerr     = (xerr && !clear) || (wr_ctl && HWDATA[tape_port_pkg::CTL_START]
			&& phase == SEQ_RUN);
		next_write_ok = (write_ok && !clear) || wr_dout;
		next_xfer     = (xfer && !clear) || word_done;
		next_clrif    = (clrif && !clear) || pin_lvl[tape_port_pkg::PIN_FAULT]; // [RL13]
		next_io_int   = (io_int && !clear) || irq_edge;
		next_tout     = (tout && !clear)
			|| (phase == SEQ_RUN && timer >= 32'(TIMEOUT_CYC - 1));
	end

	// Register sticky bits
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			start_ok <= 1'b0;
			write_ok <= 1'b0;
			xfer     <= 1'b0;
			clrif    <= 1'b0;
			io_int   <= 1'b0;
			xerr     <= 1'b0;
			tout     <= 1'b0;
		end else begin
			start_ok <= next_start_ok;
			write_ok <= next_write_ok;
			xfer     <= next_xfer;
			clrif    <= next_clrif;
			io_int   <= next_io_int;
			xerr     <= next_xerr;
			tout     <= next_tout;
		end
	end

	// Status word layout
	always_comb begin
		status                            = 16'h0000; // [RL14]
		status[tape_port_pkg::ST_START_OK] = start_ok;
		status[tape_port_pkg::ST_WRITE_OK] = write_ok;
		status[tape_port_pkg::ST_PENDING]  = xfer | clrif | io_int | xerr | tout;
		status[tape_port_pkg::ST_SEQ_A]    = cnt[0];
		status[tape_port_pkg::ST_SEQ_B]    = cnt[1];
		status[tape_port_pkg::ST_FLAG]     = pin_lvl[tape_port_pkg::PIN_FLAG];
		status[tape_port_pkg::ST_POWER]    = pin_lvl[tape_port_pkg::PIN_POWER];
		status[tape_port_pkg::ST_LOW]      = pin_lvl[tape_port_pkg::PIN_LOW];
		status[tape_port_pkg::ST_XFER]     = xfer;
		status[tape_port_pkg::ST_CLRIF]    = clrif; // [RL13]
		status[tape_port_pkg::ST_IO]       = io_int;
		status[tape_port_pkg::ST_XERR]     = xerr;
		status[tape_port_pkg::ST_TIMER]    = tout;
	end

	// ==========================================
	// Checks
	sequence s_flag_lead;
		phase == SEQ_RUN && cnt == 2'h1 && e_lead;
	endsequence
	property p_step12; // [RL1]
		@(posedge CLOCK) disable iff (!RST_B) (s_flag_lead and (timer < 32'(TIMEOUT_CYC - 1)))
			|=> cnt == 2'h2;
	endproperty
	a_step12: assert property (p_step12) else $error("count 1 did not step to 2"); // [RL1]
	property p_step23; // [RL2]
		@(posedge CLOCK) disable iff (!RST_B) step_23 && timer < 32'(TIMEOUT_CYC - 1)
			|=> cnt == 2'h3;
	endproperty
	a_step23: assert property (p_step23) else $error("count 2 did not step to 3"); // [RL2]
	property p_capture; // [RL3]
		@(posedge CLOCK) disable iff (!RST_B) $changed(data_in)
			|-> $past(cnt) == 2'h1 || $past(cnt) == 2'h3;
	endproperty
	a_capture: assert property (p_capture) else $error("data taken at wrong count"); // [RL3]
	property p_resp_hold; // [RL4]
		@(posedge CLOCK) disable iff (!RST_B) j_resp && cmd && !e_lead
			&& timer < 32'(TIMEOUT_CYC - 1) |=> cmd;
	endproperty
	a_resp_hold: assert property (p_resp_hold) else $error("command dropped early"); // [RL4]
	property p_polarity; // [RL5]
		@(posedge CLOCK) disable iff (!RST_B) !$past(j_pol) |-> DEVICE_COMMAND == cmd;
	endproperty
	a_polarity: assert property (p_polarity) else $error("command polarity wrong"); // [RL5]
	property p_no_halt; // [RL6]
		@(posedge CLOCK) disable iff (!RST_B) !j_halt && phase == SEQ_IDLE |=> !IO_HALT;
	endproperty
	a_no_halt: assert property (p_no_halt) else $error("host halted without jumper"); // [RL6]
	property p_operation_complete; // [RL9]
		@(posedge CLOCK) disable iff (!RST_B) step_23 && punch
			&& timer < 32'(TIMEOUT_CYC - 1) |=> OPERATION_COMPLETE ##1 !OPERATION_COMPLETE;
	endproperty
	a_operation_complete: assert property (p_operation_complete) else $error("done pulse missing"); // [RL9]
	property p_s10; // [RL11]
		@(posedge CLOCK) disable iff (!RST_B) !j_s10 && !io_int
			&& !pin_rise[tape_port_pkg::PIN_S9]
			&& !(punch && pin_rise[tape_port_pkg::PIN_S8]) |=> !io_int;
	endproperty
	a_s10: assert property (p_s10) else $error("status 10 raised interrupt"); // [RL11]
	property p_hold; // [RL12]
		@(posedge CLOCK) disable iff (!RST_B) reading && !j_hold |=> $stable(DATA_OUT);
	endproperty
	a_hold: assert property (p_hold) else $error("output lines moved while reading"); // [RL12]
	property p_fault; // [RL13]
		@(posedge CLOCK) disable iff (!RST_B) pin_lvl[tape_port_pkg::PIN_FAULT]
			|=> status[tape_port_pkg::ST_CLRIF] ##1 status[tape_port_pkg::ST_CLRIF];
	endproperty
	a_fault: assert property (p_fault) else $error("fault not reported"); // [RL13]
	property p_word; // [RL15]
		@(posedge CLOCK) disable iff (!RST_B) word_done |=> xfer && phase == SEQ_IDLE;
	endproperty
	a_word: assert property (p_word) else $error("word completion not flagged"); // [RL15]
endmodule : tape_port
`default_nettype wire

/* logic/tape_port_pkg.sv */
package tape_port_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_STATUS  = 8'h00; // Interrupt status word
	localparam logic [7:0] OFS_CONTROL = 8'h04; // Control order
	localparam logic [7:0] OFS_DATAOUT = 8'h08; // Word to punch
	localparam logic [7:0] OFS_DATAIN  = 8'h0C; // Word read
	// ==========================================
	// Control word fields
	localparam int CTL_START = 0; // Start a word transfer
	localparam int CTL_PUNCH = 1; // Punch configuration
	localparam int CTL_CLEAR = 2; // Clear sticky status
	localparam logic CTL_PUNCH_RST = 1'b0; // Reader after reset
	// ==========================================
	// Status word fields
	localparam int ST_START_OK = 0;
	localparam int ST_WRITE_OK = 1;
	localparam int ST_PENDING  = 2;
	localparam int ST_SEQ_A    = 3;
	localparam int ST_SEQ_B    = 4;
	localparam int ST_FLAG     = 5;
	localparam int ST_POWER    = 8;
	localparam int ST_LOW      = 9;
	localparam int ST_XFER     = 11;
	localparam int ST_CLRIF    = 12;
	localparam int ST_IO       = 13;
	localparam int ST_XERR     = 14;
	localparam int ST_TIMER    = 15;
	// ==========================================
	// Synchroniser bit positions
	localparam int PIN_FLAG  = 0;
	localparam int PIN_S8    = 1;
	localparam int PIN_S9    = 2;
	localparam int PIN_S10   = 3;
	localparam int PIN_POWER = 4;
	localparam int PIN_LOW   = 5;
	localparam int PIN_FAULT = 6;
	localparam int PIN_J     = 7;  // Nine jumpers from here
	localparam int PIN_DATA  = 16; // Eight data bits from here
	localparam int PIN_W     = 24;
	// ==========================================
	// Timing
	localparam int CLK_NS       = 40;
	localparam int CMD_PULSE_NS = 1000;
	localparam int CMD_PULSE_CYC = (CMD_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int TIMEOUT_MS   = 10;
	localparam int TIMEOUT_CYC  = (TIMEOUT_MS * 1000000) / CLK_NS;
	// ==========================================
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
endpackage : tape_port_pkg

/* logic/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-flop synchroniser with edge detect
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// Raw pins and clean results
	input  wire logic [W-1:0] raw,
	output logic      [W-1:0] level,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta; // First stage, read by second only
	logic [W-1:0] prev; // Level one cycle ago

	// Edges compare the settled level with its history
	always_comb begin
		rise = level & ~prev;
		fall = ~level & prev;
	end

	// Register all three stages
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta  <= '0;
			level <= '0;
			prev  <= '0;
		end else begin
			meta  <= raw;
			level <= meta;
			prev  <= level;
		end
	end
endmodule : pin_sync
`default_nettype wire

/* test/tape_mech_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Tape mechanism: one flag pulse per command, plus a second pulse after a punch high byte
module tape_mech_model (
	// Clock
	input  wire logic        clk,
	// From the port
	input  wire logic        command,
	// Set by the bench
	input  wire logic [15:0] word,
	input  wire logic [7:0]  delay,
	input  wire logic        punch_mode,
	// To the port
	output logic             flag,
	output logic      [7:0]  data,
	// Command level seen as the flag rises
	output logic             cmd_at_flag
);
	logic hi; // High byte goes next
	// Idle state: flag low
	initial begin
		flag = 1'b0;
		data = 8'h5A;
		hi = 1'b1;
		cmd_at_flag = 1'b0;
	end
	// Prompt or slow answer, set by delay
	always begin
		do @(posedge clk); while (command !== 1'b1);
		repeat (delay) @(posedge clk);
		data <= hi ? word[15:8] : word[7:0];
		repeat (2) @(posedge clk);
		flag <= 1'b1;
		cmd_at_flag <= command;
		do @(posedge clk); while (command === 1'b1);
		repeat (6) @(posedge clk);
		flag <= 1'b0;
		// Byte no longer held: show its inverse
		data <= ~data;
		hi <= ~hi;
		repeat (4) @(posedge clk);
		// Punch needs a second falling flag edge to step 2 to 3
		if (punch_mode && !hi) begin
			flag <= 1'b1;
			repeat (4) @(posedge clk);
			flag <= 1'b0;
			repeat (4) @(posedge clk);
		end
	end
endmodule : tape_mech_model
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ==========================================
	// Signals
	logic        clock = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_s, r;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, rdy_s, resp_s, flag, cmd, done, halt_o, cmd_at_flag;
	logic        halt_j = 1'b0, lead_j = 1'b0, resp_j = 1'b0, inen_j = 1'b0;
	logic        trail_j = 1'b1, ohold_j = 1'b0, s9_j = 1'b1, s10_j = 1'b0, pol_j = 1'b0;
	logic        s8 = 1'b0, s9 = 1'b0, s10 = 1'b0, pwr = 1'b0, low = 1'b0, fault = 1'b0;
	logic        punch = 1'b0;
	logic [7:0]  din, dout, dly = 8'h08;
	logic [15:0] word = 16'h0;
	int          errors = 0, check_count = 0, i, n;
	// ==========================================
	// Clock, bus sampling, instances
	always #20 clock = ~clock;
	// Answer of the slave as seen at each edge
	always @(posedge clock) begin
		rd_s <= hrdata;
		rdy_s <= hreadyout;
		resp_s <= hresp;
	end
	tape_port #(.TIMEOUT_CYC(200)) dut_u (
		.CLOCK(clock), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
		.HALT_OPTION_JUMPER(halt_j), .FLAG_LEAD_EDGE_JUMPER(lead_j),
		.RESPONSE_MODE_JUMPER(resp_j), .INPUT_ENABLE_JUMPER(inen_j),
		.FLAG_TRAIL_EDGE_JUMPER(trail_j), .OUTPUT_HOLD_JUMPER(ohold_j),
		.STATUS9_IRQ_JUMPER(s9_j), .STATUS10_IRQ_JUMPER(s10_j),
		.COMMAND_POLARITY_JUMPER(pol_j), .SPROCKET_HOLE_DETECT(flag),
		.STATUS8(s8), .STATUS9(s9), .STATUS10(s10), .POWER_ON(pwr),
		.SUPPLY_LOW(low), .TAPE_FAULT(fault), .DATA_IN(din), .DEVICE_COMMAND(cmd),
		.DATA_OUT(dout), .OPERATION_COMPLETE(done), .IO_HALT(halt_o)
	);
	tape_mech_model mech_u (
		.clk(clock), .command(cmd), .word(word), .delay(dly), .punch_mode(punch), .flag(flag),
		.data(din), .cmd_at_flag(cmd_at_flag)
	);
	// ==========================================
	// Helpers
	task summarize;
		$display("Counts: %0d errors, %0d checks", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] expv);
		check_count++;
		if (seen !== expv) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : check
	// Step just past the edge
	task tick;
		@(posedge clock);
		#1;
	endtask : tick
	// Single word transfer, waits for hready in both phases
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		n = 0;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= tape_port_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		do begin
			tick;
			n++;
		end while (rdy_s !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			tick;
			n++;
		end while (rdy_s !== 1'b1 && n < 100);
		check({31'h0, rdy_s}, 32'h1);
		r = rd_s;
		check({31'h0, resp_s}, 32'h0);
	endtask : bus
	// Expected status word from sticky bits and pin levels
	function automatic logic [31:0] st_exp(input logic [15:0] sticky);
		logic [15:0] s;
		s = sticky | ((|sticky) ? 16'h0004 : 16'h0000);
		s[8] = pwr;
		s[9] = low;
		return {16'h0000, s};
	endfunction : st_exp
	// Read status, acceptance flags masked
	task rd_st(input logic [15:0] sticky);
		bus(1'b0, tape_port_pkg::OFS_STATUS, 32'h0);
		check({r[31:2], 2'b00}, st_exp(sticky));
	endtask : rd_st
	// Clear sticky status, keep mode
	task clr;
		bus(1'b1, tape_port_pkg::OFS_CONTROL, {29'h0, 1'b1, punch, 1'b0});
	endtask : clr
	// Wait for a time in cycles
	task idle(input int c);
		repeat (c) tick;
	endtask : idle
	// One reader word, optionally with a refused second start
	task word_rd(input logic [15:0] w, input logic twice);
		word <= w;
		bus(1'b1, tape_port_pkg::OFS_CONTROL, 32'h1);
		tick;
		check({31'h0, cmd}, 32'h1);
		if (twice) begin
			bus(1'b1, tape_port_pkg::OFS_CONTROL, 32'h1);
		end
		i = 0;
		do begin
			bus(1'b0, tape_port_pkg::OFS_STATUS, 32'h0);
			check({24'h0, dout}, 32'h0000_005A);
			i++;
		end while (r[11] !== 1'b1 && i < 300);
		bus(1'b0, tape_port_pkg::OFS_DATAIN, 32'h0);
		check(r, {16'h0, w});
		check({24'h0, dout}, 32'h0000_005A);
		check({31'h0, halt_o}, 32'h0);
		// Let the mechanism drop its flag before status is read
		idle(12);
		rd_st(twice ? 16'h4800 : 16'h0800);
		clr;
	endtask : word_rd
	// ==========================================
	// Watchdog
	initial begin
		repeat (40000) @(posedge clock);
		errors++;
		summarize;
	end
	// ==========================================
	// Main sequence
	initial begin
		r = $urandom(53);
		pwr <= $urandom % 2;
		low <= $urandom % 2;
		repeat (5) @(posedge clock);
		#1;
		rst_b <= 1'b1;
		idle(4);
		rd_st(16'h0000);
		bus(1'b0, 8'h10, 32'h0);
		check(r, 32'h0);
		bus(1'b1, tape_port_pkg::OFS_STATUS, 32'hFFFF);
		rd_st(16'h0000);
		// Punch word whose low byte would show if lines moved
		bus(1'b1, tape_port_pkg::OFS_DATAOUT, 32'h0000_5AC3);
		// Reader words, timed and response mode, prompt and slow
		for (int k = 0; k < 6; k++) begin
			resp_j <= k[0];
			dly <= k[0] ? 8'd30 + 8'($urandom % 30) : 8'd2 + 8'($urandom % 14);
			idle(4);
			word_rd(k == 0 ? 16'h0000 : (k == 1 ? 16'hFFFF : 16'($urandom)), k == 2);
			if (k[0]) begin
				check({31'h0, cmd_at_flag}, 32'h1);
			end
		end
		resp_j <= 1'b0;
		// Status 10 without its jumper, then status 9 rise
		s10 <= 1'b1;
		idle(6);
		s10 <= 1'b0;
		idle(6);
		rd_st(16'h0000);
		s9 <= 1'b1;
		idle(6);
		rd_st(16'h2000);
		clr;
		// Tape fault
		fault <= 1'b1;
		idle(6);
		rd_st(16'h1000);
		fault <= 1'b0;
		idle(6);
		clr;
		rd_st(16'h0000);
		// Punch mode status interrupts
		punch <= 1'b1;
		bus(1'b1, tape_port_pkg::OFS_CONTROL, 32'h2);
		s8 <= 1'b1;
		idle(6);
		rd_st(16'h2000);
		clr;
		s9 <= 1'b0;
		idle(6);
		s9 <= 1'b1;
		idle(6);
		rd_st(16'h2000);
		clr;
		// Punch word: high byte out first, low byte after the 2-3 step
		word <= 16'($urandom);
		dly <= 8'h04;
		bus(1'b1, tape_port_pkg::OFS_DATAOUT, 32'h0000_A53C);
		bus(1'b1, tape_port_pkg::OFS_CONTROL, 32'h3);
		idle(2);
		check({24'h0, dout}, 32'h0000_00A5);
		i = 0;
		while (done !== 1'b1 && i < 150) begin
			tick;
			i++;
		end
		check({31'h0, done}, 32'h1);
		check({24'h0, dout}, 32'h0000_003C);
		tick;
		check({31'h0, done}, 32'h0);
		idle(60);
		rd_st(16'h0800);
		clr;
		// Mechanism too slow: the transfer watchdog aborts
		dly <= 8'hFA;
		bus(1'b1, tape_port_pkg::OFS_CONTROL, 32'h3);
		idle(300);
		rd_st(16'h8000);
		summarize;
	end
endmodule : tb_top
`default_nettype wire
